// ### hdl/voltage_id_register_control.sv
// Voltage-ID register control: serial slave, level register and transition timing.
// Assumes analog regulation, comparators and soft-start reference live outside.
//
// Function
// - Supply register bit 0 shows window flag.
// - Device recomputes XOR and compares checksum bit.
// - Bad checksum leaves output level unchanged.
// - Low seven bits select one of 128 levels.
// - Level selector defaults to code 50.
// - External feedback regulates until code programmed.
// - Enable high with supply present starts the soft-start ramp.
// - Serial port active only once output regulates.
// - Code 0 is 600 mV, 10 mV per step.
// - Ten-millivolt steps hold for default divider only.
// - Level change forces continuous conduction for 100 us.
// - Level change masks the window flag 100 us.
// - Valid level write enters register-controlled mode.
// - Bad checksum changes no register or mode bit.
// - Level register at 00h, supply register 18h.
// - Three-byte write, four-byte read, single byte only.
// - Answer only slave address 31h.
module voltage_id_register_control #(
   parameter logic [15:0] SOFT_START_CYCLES = vid_ctrl_pkg::SOFT_START_DEFAULT
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic enable_in,
   input wire logic supply_present_in,
   input wire logic feedback_input_in,
   output logic [6:0] output_level_code_out,
   output logic [10:0] target_millivolts_out,
   output logic register_controlled_level_mode_out,
   output logic continuous_conduction_switching_out,
   output logic regulation_window_flag_out,
   output logic soft_start_ramp_out,
   output logic serial_active_out
);

   vid_ctrl_pkg::sys_state_t st;
   vid_ctrl_pkg::sys_state_t next_st;
   vid_ctrl_pkg::level_write_t wr;
   logic en_s;
   logic supply_s;
   logic fb_s;
   logic scl_s;
   logic sda_s;
   logic tgl_s;
   logic wr_evt;
   logic par_ok;

   // ----------------------------------------------------------------
   // Pin and link synchronisers
   // ----------------------------------------------------------------
   level_sync #(.WIDTH(6)) u_sync (
      .clk_in(clk_in),
      .async_in({enable_in, supply_present_in, feedback_input_in, scl_in, sda_in, wr.tgl}),
      .sync_out({en_s, supply_s, fb_s, scl_s, sda_s, tgl_s})
   );

   // ----------------------------------------------------------------
   // Serial slave on the master's clock
   // ----------------------------------------------------------------
   vid_serial_link u_link (
      .scl_in(scl_in),
      .sda_in(sda_in),
      .link_enable_in(st.idle_seen),
      .window_flag_in(regulation_window_flag_out),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .level_write_out(wr)
   );

   // ----------------------------------------------------------------
   // Write acceptance
   // ----------------------------------------------------------------
   // The code word stays still in the link domain from its toggle until the
   // next data byte, many serial clocks later, so it is taken on the toggle.
   assign wr_evt = tgl_s ^ st.tgl_q;
   assign par_ok = !(^wr.code);

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.tgl_q = tgl_s;
      if (wr_evt && par_ok) begin
         next_st.code = wr.code;
         next_st.register_controlled_level_mode = 1'b1;
         next_st.mask_cnt = vid_ctrl_pkg::TRANSITION_CYCLES;
      end else if (st.mask_cnt != 12'h000) begin
         next_st.mask_cnt = st.mask_cnt - 12'h001;
      end
      if (!en_s || !supply_s) begin
         next_st.ss_cnt = 16'h0000;
         next_st.ss_done = 1'b0;
      end else if (!st.ss_done) begin
         if (st.ss_cnt == SOFT_START_CYCLES - 16'h0001) begin
            next_st.ss_done = 1'b1;
         end else begin
            next_st.ss_cnt = st.ss_cnt + 16'h0001;
         end
      end
      if (!(st.ss_done && supply_s && fb_s) && !st.idle_seen) begin
         next_st.idle_seen = 1'b0;
      end else if (!st.ss_done || !supply_s || !en_s) begin
         next_st.idle_seen = 1'b0;
      end else if (scl_s && sda_s) begin
         next_st.idle_seen = 1'b1;
      end
      if (sys_rst_in) begin
         next_st = '0;
         next_st.code = vid_ctrl_pkg::LEVEL_RESET;
         next_st.tgl_q = tgl_s;
      end
   end

   always_ff @(posedge clk_in) begin
      st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign output_level_code_out = st.code[6:0];
   // Low mode keeps the regulator on its external divider and initial reference.
   assign register_controlled_level_mode_out = st.register_controlled_level_mode;
   assign continuous_conduction_switching_out = st.mask_cnt != 12'h000;
   assign regulation_window_flag_out = fb_s && st.mask_cnt == 12'h000;
   assign soft_start_ramp_out = en_s && supply_s && !st.ss_done;
   assign serial_active_out = st.idle_seen;
   // Holds only for the default divider; other dividers scale the step.
   assign target_millivolts_out = vid_ctrl_pkg::BASE_MV +
      11'(st.code[6:0]) * vid_ctrl_pkg::STEP_MV;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_accept;
      wr_evt && par_ok;
   endsequence

   sequence s_reject;
      wr_evt && !par_ok;
   endsequence

   AST_BAD_KEEPS_CODE: assert property (s_reject |=> $stable(output_level_code_out))
      else $error("Rejected write changed the level.");

   AST_BAD_KEEPS_MODE: assert property ((s_reject and !st.register_controlled_level_mode) |=>
      !register_controlled_level_mode_out)
      else $error("Rejected write set the mode.");

   AST_GOOD_SETS_MODE: assert property (s_accept |=> register_controlled_level_mode_out &&
      output_level_code_out == $past(wr.code[6:0]))
      else $error("Accepted write not applied.");

   AST_MASK_HOLDS: assert property (s_accept |=> (!regulation_window_flag_out)[*8])
      else $error("Window flag shown during transition.");

   AST_CCM_ON_CHANGE: assert property (s_accept |=> continuous_conduction_switching_out &&
      st.mask_cnt == vid_ctrl_pkg::TRANSITION_CYCLES)
      else $error("Forced conduction not started.");

   AST_FLAG_FOLLOWS: assert property (st.mask_cnt == 12'h000 |->
      regulation_window_flag_out == fb_s)
      else $error("Window flag does not follow comparator.");

   AST_RESET_CODE: assert property ($fell(sys_rst_in) |->
      output_level_code_out == vid_ctrl_pkg::LEVEL_RESET[6:0] &&
      !register_controlled_level_mode_out)
      else $error("Wrong level after reset.");

   AST_CODE_CAUSE: assert property ($changed(output_level_code_out) |->
      $past(wr_evt) || $past(sys_rst_in))
      else $error("Level changed without a write.");

   AST_RAMP_ON_ENABLE: assert property ($rose(en_s) && supply_s && !st.ss_done |->
      soft_start_ramp_out ##1 (soft_start_ramp_out || st.ss_done))
      else $error("Soft start not begun on enable.");

   AST_SERIAL_AFTER_REG: assert property (serial_active_out |-> st.ss_done &&
      $past(supply_s))
      else $error("Serial port active before regulation.");

   AST_ZERO_CODE_MV: assert property (output_level_code_out == 7'h00 |->
      target_millivolts_out == vid_ctrl_pkg::BASE_MV)
      else $error("Code zero target wrong.");

endmodule : voltage_id_register_control

// ### hdl/vid_ctrl_pkg.sv
// Constants and carrier types shared by the voltage-ID register block.
// Assumes a 25 MHz system clock and an external I2C master driving the serial clock.
package vid_ctrl_pkg;

   // ----------------------------------------------------------------
   // Serial interface addresses, level reset code and bit slots
   // ----------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h31;
   localparam logic [7:0] LEVEL_REG_ADDR = 8'h00;
   localparam logic [7:0] SUPPLY_REG_ADDR = 8'h18;
   localparam logic [7:0] LEVEL_RESET = 8'h32;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int TRANSITION_US = 100;
   localparam logic [11:0] TRANSITION_CYCLES = 12'(TRANSITION_US * CLK_MHZ);
   localparam logic [15:0] SOFT_START_DEFAULT = 16'h2710;

   // ----------------------------------------------------------------
   // Output level scale
   // ----------------------------------------------------------------
   localparam logic [10:0] BASE_MV = 11'h258;
   localparam logic [10:0] STEP_MV = 11'h00A;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      PH_IDLE = 6'h01,
      PH_ADDR = 6'h02,
      PH_REG = 6'h04,
      PH_WDATA = 6'h08,
      PH_RDATA = 6'h10,
      PH_SKIP = 6'h20
   } link_phase_t;

   typedef struct packed {
      logic tgl;
      logic [7:0] code;
   } level_write_t;

   typedef struct packed {
      link_phase_t phase;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] reg_sel;
      logic pull;
      level_write_t wr;
   } link_state_t;

   typedef struct packed {
      logic [7:0] code;
      logic register_controlled_level_mode;
      logic [11:0] mask_cnt;
      logic [15:0] ss_cnt;
      logic ss_done;
      logic idle_seen;
      logic tgl_q;
   } sys_state_t;

endpackage : vid_ctrl_pkg

// ### hdl/level_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit changes slowly against the destination clock.
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
         meta[i] <= async_in[i];
         sync_out[i] <= meta[i];
      end
   end

endmodule : level_sync

// ### hdl/vid_serial_link.sv
// Serial slave that runs on the master's clock line.
// Assumes the master keeps data stable while the clock is high and never stretches.
module vid_serial_link (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic link_enable_in,
   input wire logic window_flag_in,
   output logic sda_out,
   output logic sda_oe_out,
   output vid_ctrl_pkg::level_write_t level_write_out
);

   vid_ctrl_pkg::link_state_t st;
   vid_ctrl_pkg::link_state_t next_st;
   logic sda_rise;
   logic en_s;
   logic win_s;
   logic [7:0] full;
   logic [7:0] rd_byte;
   logic ok;

   // ----------------------------------------------------------------
   // Crossings and capture
   // ----------------------------------------------------------------
   level_sync #(.WIDTH(2)) u_sync (
      .clk_in(~scl_in),
      .async_in({link_enable_in, window_flag_in}),
      .sync_out({en_s, win_s})
   );

   // Data is sampled on the rising edge; all state moves on the falling edge.
   always_ff @(posedge scl_in) begin
      sda_rise <= sda_in;
   end

   // ----------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      ok = 1'b0;
      full = {st.shift[6:0], sda_rise};
      rd_byte = (st.reg_sel == vid_ctrl_pkg::SUPPLY_REG_ADDR) ?
                {7'h00, win_s} : st.wr.code;
      if (!en_s) begin
         next_st = '0;
         next_st.phase = vid_ctrl_pkg::PH_IDLE;
         next_st.wr.code = vid_ctrl_pkg::LEVEL_RESET;
         // The cleared toggle may raise one write event on the system side; the
         // held reset code fails the checksum there, so that event is refused.
      end else if (sda_rise && !sda_in) begin
         next_st.phase = vid_ctrl_pkg::PH_ADDR;
         next_st.cnt = 4'h0;
         next_st.pull = 1'b0;
      end else begin
         unique case (st.phase)
            vid_ctrl_pkg::PH_IDLE, vid_ctrl_pkg::PH_SKIP: begin
               next_st.pull = 1'b0;
            end
            vid_ctrl_pkg::PH_RDATA: begin
               next_st.cnt = st.cnt + 4'h1;
               next_st.shift = {st.shift[6:0], 1'b0};
               next_st.pull = (st.cnt < vid_ctrl_pkg::BYTE_LAST) && !st.shift[6];
               if (st.cnt == vid_ctrl_pkg::ACK_SLOT) begin
                  next_st.phase = vid_ctrl_pkg::PH_SKIP;
               end
            end
            default: begin
               if (st.cnt == vid_ctrl_pkg::ACK_SLOT) begin
                  next_st.cnt = 4'h0;
                  next_st.pull = 1'b0;
                  if (st.phase == vid_ctrl_pkg::PH_ADDR && st.shift[0]) begin
                     next_st.phase = vid_ctrl_pkg::PH_RDATA;
                     next_st.shift = rd_byte;
                     next_st.pull = !rd_byte[7];
                  end else if (st.phase == vid_ctrl_pkg::PH_ADDR) begin
                     next_st.phase = vid_ctrl_pkg::PH_REG;
                  end else if (st.phase == vid_ctrl_pkg::PH_REG) begin
                     next_st.phase = vid_ctrl_pkg::PH_WDATA;
                  end else begin
                     next_st.phase = vid_ctrl_pkg::PH_SKIP;
                  end
               end else begin
                  next_st.cnt = st.cnt + 4'h1;
                  next_st.shift = full;
               end
               if (st.cnt == vid_ctrl_pkg::BYTE_LAST) begin
                  unique case (st.phase)
                     vid_ctrl_pkg::PH_ADDR: begin
                        ok = full[7:1] == vid_ctrl_pkg::SLAVE_ADDR;
                     end
                     vid_ctrl_pkg::PH_REG: begin
                        ok = full == vid_ctrl_pkg::LEVEL_REG_ADDR ||
                             full == vid_ctrl_pkg::SUPPLY_REG_ADDR;
                        next_st.reg_sel = full;
                     end
                     default: begin
                        ok = !(^full);
                        if (st.reg_sel == vid_ctrl_pkg::LEVEL_REG_ADDR && ok) begin
                           next_st.wr.code = full;
                           next_st.wr.tgl = !st.wr.tgl;
                        end
                     end
                  endcase
                  next_st.pull = ok;
                  if (!ok) begin
                     next_st.phase = vid_ctrl_pkg::PH_SKIP;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(negedge scl_in) begin
      st <= next_st;
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = st.pull;
   assign level_write_out = st.wr;

   AST_FOREIGN_NO_ACK: assert property (@(negedge scl_in) disable iff (!en_s)
      (st.phase == vid_ctrl_pkg::PH_ADDR && st.cnt == vid_ctrl_pkg::BYTE_LAST &&
       full[7:1] != vid_ctrl_pkg::SLAVE_ADDR && !(sda_rise && !sda_in))
      |=> !sda_oe_out ##1 !sda_oe_out)
      else $error("Foreign address was acknowledged.");

endmodule : vid_serial_link

// ### testbench/i2c_master_model.sv
// Behavioural serial bus master that drives the clock and data lines of the link.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module i2c_master_model (
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out,
   output logic [7:0] rx_byte_out,
   output logic rx_done_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // The clock idles high on its pull-up and moves only inside frames and flushes.
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
      rx_byte_out = 8'h00;
      rx_done_out = 1'b0;
   end

   task automatic pulse(input logic bit_in, output logic seen);
      // Data moves only once the falling clock edge has passed.
      #1 sda_low_out = ~bit_in;
      #5 scl_out = 1'b1;
      #5 seen = sda_in;
      #1 scl_out = 1'b0;
   endtask : pulse

   task automatic flush();
      logic seen;
      repeat (3) pulse(1'b1, seen);
      // The clock is left high on its pull-up.
      #6 scl_out = 1'b1;
   endtask : flush

   task automatic start();
      // The slave sees a start only after a rising clock edge with data high.
      #1 sda_low_out = 1'b0;
      scl_out = 1'b0;
      #5 scl_out = 1'b1;
      #3 sda_low_out = 1'b1;
      #3 scl_out = 1'b0;
   endtask : start

   task automatic stop();
      #1 sda_low_out = 1'b1;
      #5 scl_out = 1'b1;
      #3 sda_low_out = 1'b0;
      #3;
   endtask : stop

   // Sends a byte most significant bit first and returns the acknowledge slot.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         pulse(tx[i], seen);
         rx[i] = seen;
      end
      pulse(1'b1, seen);
      ack = ~seen;
   endtask : xfer

   task automatic write_reg(input logic [7:0] addr, ra, data, output logic [2:0] ak);
      logic [7:0] rx;
      start();
      xfer(addr, rx, ak[2]);
      xfer(ra, rx, ak[1]);
      xfer(data, rx, ak[0]);
      stop();
   endtask : write_reg

   task automatic read_reg(input logic [7:0] ra, output logic [1:0] ak);
      logic [7:0] rx;
      logic nk;
      logic ra_ack;
      start();
      xfer({vid_ctrl_pkg::SLAVE_ADDR, 1'b0}, rx, ak[1]);
      xfer(ra, rx, ak[0]);
      start();
      xfer({vid_ctrl_pkg::SLAVE_ADDR, 1'b1}, rx, ra_ack);
      xfer(8'hFF, rx, nk);
      stop();
      rx_byte_out = rx;
      rx_done_out = ~rx_done_out;
   endtask : read_reg
endmodule : i2c_master_model

// ### testbench/tb.sv
// Self-checking bench for the voltage-ID register block.
// Assumes a pull-up on the data wire and the master model in its own file.
`define CHK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp); \
   end \
end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] SLV_W = {vid_ctrl_pkg::SLAVE_ADDR, 1'b0};
   logic clk_in, sys_rst_in, enable_in, supply_present_in, feedback_input_in;
   logic scl, sda_low, sda_line, sda_out, sda_oe_out, mode, continuous_conduction_switching, flag, ramp, active;
   logic rx_done, ccm_prev;
   logic [6:0] code, last_c;
   logic [10:0] mv;
   logic [7:0] rx_byte, exp_b;
   logic [7:0] lvl_q[$];
   logic [7:0] rd_q[$];
   logic [31:0] seed = 32'h1846;
   int failures, check_count, ccm_len;

   assign sda_line = ~(sda_low | (sda_oe_out & ~sda_out));

   voltage_id_register_control #(.SOFT_START_CYCLES(16'h0014)) u_dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .enable_in(enable_in),
      .supply_present_in(supply_present_in), .feedback_input_in(feedback_input_in),
      .output_level_code_out(code), .target_millivolts_out(mv),
      .register_controlled_level_mode_out(mode),
      .continuous_conduction_switching_out(continuous_conduction_switching), .regulation_window_flag_out(flag),
      .soft_start_ramp_out(ramp), .serial_active_out(active));

   i2c_master_model u_master (.sda_in(sda_line), .scl_out(scl), .sda_low_out(sda_low),
      .rx_byte_out(rx_byte), .rx_done_out(rx_done));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc

   task automatic wr(input logic [7:0] a, ra, d, input logic [2:0] exp);
      logic [2:0] ak;
      u_master.write_reg(a, ra, d, ak);
      `CHK(ak, exp)
   endtask : wr

   task automatic rd(input logic [7:0] ra, exp);
      logic [1:0] ak;
      rd_q.push_back(exp);
      u_master.read_reg(ra, ak);
      `CHK(ak, 2'b11)
   endtask : rd

   task automatic vw(input logic [6:0] c);
      int n;
      n = 0;
      exp_b = {^c, c};
      last_c = c;
      lvl_q.push_back(exp_b);
      wr(SLV_W, 8'h00, exp_b, 3'b111);
      rd(8'h00, {^c, c});
      rd(8'h18, 8'h00);
      while (lvl_q.size() != 0 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 3000) begin
         failures++;
         results();
      end
      rd(8'h18, 8'h01);
   endtask : vw

   // ----------------------------------------------------------------
   // Output watchers
   // ----------------------------------------------------------------
   always @(negedge clk_in) begin
      if (continuous_conduction_switching) begin
         ccm_len++;
         `CHK(flag, 1'b0)
      end
      if (ccm_prev && !continuous_conduction_switching) begin
         exp_b = lvl_q.pop_front();
         `CHK(ccm_len, 2500)
         `CHK(code, exp_b[6:0])
         `CHK(mv, vid_ctrl_pkg::BASE_MV + vid_ctrl_pkg::STEP_MV * 11'(exp_b[6:0]))
         `CHK(mode, 1'b1)
         ccm_len = 0;
      end
      ccm_prev = continuous_conduction_switching;
   end

   always @(rx_done) begin
      if (rd_q.size() != 0) begin
         `CHK(rx_byte, rd_q.pop_front())
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      sys_rst_in = 1'b1;
      enable_in = 1'b0;
      supply_present_in = 1'b0;
      feedback_input_in = 1'b0;
      ccm_prev = 1'b0;
      ccm_len = 0;
      cyc(10);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      `CHK(code, 7'h32)
      `CHK(mv, 11'h44C)
      `CHK(mode, 1'b0)
      `CHK(active, 1'b0)
      `CHK(sda_out, 1'b0)
      // Clock the link while it is disabled so that it clears itself.
      u_master.flush();
      @(posedge clk_in);
      enable_in <= 1'b1;
      supply_present_in <= 1'b1;
      cyc(5);
      @(negedge clk_in);
      `CHK(ramp, 1'b1)
      cyc(40);
      @(negedge clk_in);
      `CHK(ramp, 1'b0)
      `CHK(active, 1'b0)
      @(posedge clk_in);
      feedback_input_in <= 1'b1;
      n = 0;
      while (active !== 1'b1 && n < 50) begin
         @(posedge clk_in);
         n++;
      end
      `CHK(active, 1'b1)
      if (active !== 1'b1) begin
         results();
      end
      $display("test power-up done");
      cyc(15);
      u_master.flush();
      rd(8'h00, 8'h32);
      rd(8'h18, 8'h01);
      vw(7'h00);
      vw(7'h7F);
      repeat (4) vw(7'(xs()));
      $display("test valid levels done");
      wr(SLV_W, 8'h00, {~^7'h15, 7'h15}, 3'b110);
      cyc(100);
      @(negedge clk_in);
      `CHK(code, last_c)
      `CHK(continuous_conduction_switching, 1'b0)
      rd(8'h00, {^last_c, last_c});
      vw(7'h15);
      $display("test checksum done");
      wr(8'h60, 8'h00, 8'h81, 3'b000);
      wr(SLV_W, 8'h05, 8'h81, 3'b100);
      wr(SLV_W, 8'h18, 8'h81, 3'b111);
      cyc(100);
      @(negedge clk_in);
      `CHK(code, last_c)
      `CHK(continuous_conduction_switching, 1'b0)
      rd(8'h18, 8'h01);
      $display("test refusals done");
      // A disable returns the link's held code to 32h; the system side keeps its own.
      @(posedge clk_in);
      enable_in <= 1'b0;
      cyc(5);
      @(negedge clk_in);
      `CHK(active, 1'b0)
      `CHK(ramp, 1'b0)
      u_master.flush();
      @(posedge clk_in);
      enable_in <= 1'b1;
      n = 0;
      while (active !== 1'b1 && n < 100) begin
         @(posedge clk_in);
         n++;
      end
      `CHK(active, 1'b1)
      cyc(15);
      u_master.flush();
      @(negedge clk_in);
      `CHK(code, last_c)
      `CHK(mode, 1'b1)
      `CHK(continuous_conduction_switching, 1'b0)
      rd(8'h00, vid_ctrl_pkg::LEVEL_RESET);
      $display("test restart done");
      results();
   end
endmodule : tb
